// File: ptpev_cfg.svh
// Constants of the PTP event trigger and stamp control block:
// register byte offsets, field positions, reset values, counter width.
// Included by the package and the top module; definitions only.
`ifndef PTPEV_CFG_SVH
`define PTPEV_CFG_SVH

// Register byte offsets on the Avalon-MM slave
`define PTPEV_AW 12
`define PTPEV_OFS_TSCS 12'h52c
`define PTPEV_OFS_TNS 12'h530
`define PTPEV_OFS_TSEC 12'h534
`define PTPEV_OFS_CTL1 12'h538
`define PTPEV_OFS_INDEX 12'h5f0
`define PTPEV_OFS_ISTAT 12'h5f4
`define PTPEV_OFS_IMASK 12'h5f8
`define PTPEV_OFS_TSSTAT 12'h5fc

// Global unit index register fields
`define PTPEV_IDX_TS_BIT 8

// Timestamp control and status fields
`define PTPEV_TSCS_ACT 4
`define PTPEV_TSCS_TEN 3
`define PTPEV_TSCS_TSRST 2
`define PTPEV_TSCS_SEN 1
`define PTPEV_TSCS_SSRST 0

// Trigger control 1 fields
`define PTPEV_C1_CHAIN 31
`define PTPEV_C1_TAIL 30
`define PTPEV_C1_UPS_HI 27
`define PTPEV_C1_UPS_LO 26
`define PTPEV_C1_NOW 25
`define PTPEV_C1_NOTIFY 24
`define PTPEV_C1_EDGE 23

// Interrupt status / mask layout
`define PTPEV_IS_DONE 0
`define PTPEV_IS_ERR 4
`define PTPEV_IS_RDY 8
`define PTPEV_IS_W 10

// Input unit status fields
`define PTPEV_TSS_OVF 4
`define PTPEV_TSS_RDY 5

// Widths and reset values
`define PTPEV_CNT_W 4
`define PTPEV_NS_W 30
`define PTPEV_RST_WORD 32'h0000_0000

`endif

// File: ptpev_chk.sv
// Port-level assertions of the PTP event trigger and stamp control block.
// Assumes the bench keeps the unit index and event pins still between a control write and its read-back.
`include "ptpev_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ptpev_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [`PTPEV_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire ptpev_pkg::ptpev_time_t sys_time,
   input wire logic [1:0] stamp_event_in,
   input wire logic [3:0] trig_out,
   input wire logic irq
);
   import ptpev_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic cs_wr;
   logic st_rd;
   // Taken control writes with lane 0 and taken input status reads
   assign cs_wr = avs_write && avs_waitrequest && avs_address == `PTPEV_OFS_TSCS && avs_byteenable[0];
   assign st_rd = avs_read && avs_waitrequest && avs_address == `PTPEV_OFS_TSSTAT;
   wait_rest_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped with no request");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not exactly one cycle after take");
   ns_resv_a: assert property (avs_read && avs_waitrequest && avs_address == `PTPEV_OFS_TNS |=> avs_readdata[31:30] == 2'b00)
      else $error("reserved nanosecond bits read nonzero");
   pulse_one_a: assert property (trig_out != 4'h0 |=> (trig_out & $past(trig_out)) == 4'h0)
      else $error("trigger pulse longer than one cycle");
   // Status read with nothing firing: interrupt must be gone two cycles on
   irq_clear_a: assert property (avs_read && avs_waitrequest && avs_address == `PTPEV_OFS_ISTAT && trig_out == 4'h0 ##1
      (trig_out == 4'h0 && $stable(stamp_event_in))[*2] |-> !irq)
      else $error("interrupt still high after status read");
   cnt_clear_a: assert property (cs_wr && avs_writedata[1:0] == 2'b10 && $stable(stamp_event_in) ##1
      $stable(stamp_event_in)[*2] ##1 (st_rd && $stable(stamp_event_in)) |=> avs_readdata[3:0] == 4'h0)
      else $error("event count not cleared by enable");
   flag_clear_a: assert property (cs_wr && avs_writedata[1:0] == 2'b00 && $stable(stamp_event_in) ##1
      $stable(stamp_event_in)[*2] ##1 (st_rd && $stable(stamp_event_in)) |=> avs_readdata[5:4] == 2'b00)
      else $error("ready or overflow not cleared by disable");
   in_reset_a: assert property (cs_wr && avs_writedata[0] && $stable(stamp_event_in) ##1
      $stable(stamp_event_in)[*2] ##1 (st_rd && $stable(stamp_event_in)) |=> avs_readdata[5:0] == 6'h00)
      else $error("input unit not at defaults in soft reset");
endmodule : ptpev_chk
bind ptpev_top ptpev_chk i_ptpev_chk (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_time(sys_time),
   .stamp_event_in(stamp_event_in), .trig_out(trig_out), .irq(irq));
`default_nettype wire

// File: ptpev_pkg.sv
// Types of the PTP event trigger and stamp control block.
// Assumes ptpev_cfg.svh is on the include path.
`include "ptpev_cfg.svh"

package ptpev_pkg;

   // Trigger unit sequencing states
   typedef enum logic [2:0] {
      TU_IDLE = 3'b001,
      TU_ARM = 3'b010,
      TU_WAIT = 3'b100
   } ptpev_tu_st_t;

   // Running system time as seen by the comparators
   typedef struct packed {
      logic [31:0] sec;
      logic [`PTPEV_NS_W-1:0] ns;
   } ptpev_time_t;

   // One trigger output unit: settings and sequencing state
   typedef struct packed {
      logic chain_mode_enable;
      logic tail;
      logic [1:0] upsel;
      logic now;
      logic notify;
      logic edge_neg;
      logic [`PTPEV_NS_W-1:0] target_nanoseconds;
      logic [31:0] target_seconds;
      logic en;
      logic output_unit_soft_reset;
      ptpev_tu_st_t st;
   } ptpev_tu_t;

   // One timestamp input unit
   typedef struct packed {
      logic stamp_unit_enable;
      logic input_unit_soft_reset;
      logic prev;
      logic capture_ready_flag;
      logic detect_count_overflow;
      logic [`PTPEV_CNT_W-1:0] event_detect_count;
   } ptpev_iu_t;

   // Whole rising-edge state of the top module
   typedef struct packed {
      ptpev_tu_t [3:0] tu;
      ptpev_iu_t [1:0] iu;
      logic [1:0] tidx;
      logic sidx;
      logic [`PTPEV_IS_W-1:0] stat;
      logic [`PTPEV_IS_W-1:0] mask;
      logic [31:0] rdata;
      logic waitreq;
      logic [3:0] pulse;
      logic irq;
   } ptpev_state_t;

endpackage : ptpev_pkg

// File: ptpev_tb_top.sv
// Self-checking bench of the PTP event trigger and stamp control block.
// Drives all ports itself; system time is a counter made here, one nanosecond per clock.
`include "ptpev_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ptpev_tb_top;
   import ptpev_pkg::*;
   localparam logic [11:0] a_cs = `PTPEV_OFS_TSCS;
   localparam logic [11:0] a_ns = `PTPEV_OFS_TNS;
   localparam logic [11:0] a_s = `PTPEV_OFS_TSEC;
   localparam logic [11:0] a_c1 = `PTPEV_OFS_CTL1;
   localparam logic [11:0] a_ix = `PTPEV_OFS_INDEX;
   localparam logic [11:0] a_is = `PTPEV_OFS_ISTAT;
   localparam logic [11:0] a_im = `PTPEV_OFS_IMASK;
   localparam logic [11:0] a_st = `PTPEV_OFS_TSSTAT;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   ptpev_time_t sys_time = {32'h0000_0005, 30'h0};
   logic [1:0] stamp_event_in = 2'b00;
   logic [3:0] trig_out;
   logic irq;
   logic [31:0] q;
   int fail_count = 0;
   int compares = 0;
   int pcnt [4] = '{0, 0, 0, 0};
   time rise_t = 0;
   ptpev_top i_ptpev_top (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_time(sys_time),
      .stamp_event_in(stamp_event_in), .trig_out(trig_out), .irq(irq));
   always #20 clk = ~clk;
   // Time source and pulse counters; counts are compared as differences to avoid clearing races
   always @(posedge clk) begin
      sys_time.ns <= sys_time.ns + 30'h1;
      for (int i = 0; i < 4; i++) begin
         if (trig_out[i] === 1'b1) pcnt[i] <= pcnt[i] + 1;
      end
   end
   // Edge timing of unit 0 tells which clock edge launched it
   always @(posedge trig_out[0]) rise_t = $time;
   task results();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One Avalon transfer: request held until waitrequest is sampled low
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         chk("waitrequest", 32'h0, 32'h1);
         results();
      end
   endtask : bus
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rdc
   task wait_trig(input int u);
      int n;
      n = 0;
      while (trig_out[u] !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200) begin
         chk("trigger", 32'h1, 32'h0);
         results();
      end
   endtask : wait_trig
   task ev(input int k);
      repeat (k) begin
         @(posedge clk);
         stamp_event_in <= 2'b10;
         @(posedge clk);
         stamp_event_in <= 2'b00;
      end
   endtask : ev
   task t_regs();
      for (int u = 0; u < 4; u++) begin
         wr(a_ix, 32'(u));
         rdc(a_s, 32'h0, "seconds reset");
         wr(a_ns, 32'hffff_fff0 ^ 32'(u));
         wr(a_s, 32'ha5a5_0000 + 32'(u));
      end
      for (int u = 0; u < 4; u++) begin
         wr(a_ix, 32'(u));
         rdc(a_ns, 32'h3fff_fff0 ^ 32'(u), "target ns");
         rdc(a_s, 32'ha5a5_0000 + 32'(u), "target s");
      end
      // Partial lanes merge over the stored word of unit 3
      avs_byteenable <= 4'h3;
      wr(a_s, 32'h1234_5678);
      avs_byteenable <= 4'hf;
      rdc(a_s, 32'ha5a5_5678, "lane merge");
      wr(a_c1, 32'hcf80_0000);
      rdc(a_c1, 32'hcf80_0000, "control");
      wr(a_c1, 32'h0);
      rdc(12'h100, 32'h0, "unmapped");
      $display("test regs done");
   endtask : t_regs
   task t_fire(input logic eg);
      logic [29:0] tg;
      tg = sys_time.ns + 30'd40;
      wr(a_ix, 32'h0);
      wr(a_im, 32'h3ff);
      wr(a_ns, {2'b00, tg});
      wr(a_s, 32'h5);
      wr(a_c1, 32'h0100_0000 | {8'h00, eg, 23'h0});
      wr(a_cs, 32'h8);
      wait_trig(0);
      chk("fire time", 32'h1, 32'(sys_time.ns >= tg && sys_time.ns <= tg + 30'd4));
      chk("edge", eg ? 32'd0 : 32'd20, 32'(rise_t % 40));
      rdc(a_cs, 32'h0, "enable self clear");
      chk("irq", 32'h1, {31'h0, irq});
      rdc(a_is, 32'h1, "done status");
      rdc(a_is, 32'h0, "status clear");
      $display("test fire done");
   endtask : t_fire
   task t_past();
      int c;
      wr(a_ix, 32'h1);
      wr(a_s, 32'h4);
      wr(a_ns, 32'h0);
      wr(a_c1, 32'h0100_0000);
      c = pcnt[1];
      wr(a_cs, 32'h8);
      rdc(a_is, 32'h20, "past error");
      chk("no fire", 32'(c), 32'(pcnt[1]));
      wr(a_c1, 32'h0300_0000);
      wr(a_cs, 32'h8);
      rdc(a_is, 32'h2, "fire now");
      wr(a_c1, 32'h0200_0000);
      wr(a_cs, 32'h8);
      rdc(a_is, 32'h0, "silent");
      chk("fires", 32'(c + 2), 32'(pcnt[1]));
      $display("test past done");
   endtask : t_past
   task t_chain(input logic tl);
      int c;
      wr(a_ix, 32'h0);
      wr(a_s, 32'h4);
      wr(a_c1, 32'h8600_0000);
      wr(a_ix, 32'h1);
      wr(a_s, 32'h4);
      wr(a_c1, 32'h8200_0000 | {1'b0, tl, 30'h0});
      wr(a_ix, 32'h0);
      c = pcnt[1];
      wr(a_cs, 32'h8);
      repeat (60) @(posedge clk);
      if (tl) chk("chain once", 32'(c + 1), 32'(pcnt[1]));
      else chk("chain loops", 32'h1, 32'(pcnt[1] - c > 3));
      wr(a_cs, 32'h4);
      wr(a_ix, 32'h1);
      wr(a_cs, 32'h4);
      c = pcnt[0] + pcnt[1];
      repeat (20) @(posedge clk);
      chk("stopped", 32'(c), 32'(pcnt[0] + pcnt[1]));
      wr(a_cs, 32'h0);
      rdc(a_c1, 32'h0, "defaults");
      wr(a_ix, 32'h0);
      wr(a_cs, 32'h0);
      $display("test chain done");
   endtask : t_chain
   task t_stamp();
      wr(a_im, 32'h0);
      wr(a_ix, 32'h100);
      wr(a_cs, 32'h2);
      ev(3);
      rdc(a_st, 32'h23, "count");
      chk("irq masked", 32'h0, {31'h0, irq});
      rdc(a_is, 32'h200, "event status");
      wr(a_cs, 32'h2);
      rdc(a_st, 32'h20, "count clear");
      wr(a_cs, 32'h0);
      rdc(a_st, 32'h0, "flags clear");
      wr(a_cs, 32'h2);
      ev(16);
      rdc(a_st, 32'h3f, "overflow");
      wr(a_cs, 32'h1);
      rdc(a_st, 32'h0, "soft reset");
      wr(a_cs, 32'h0);
      wr(a_ix, 32'h0);
      rdc(a_st, 32'h0, "other unit");
      $display("test stamp done");
   endtask : t_stamp
   // Main sequence: reset for six clocks, then every scenario in turn
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_fire(1'b0);
      t_fire(1'b1);
      t_past();
      t_chain(1'b0);
      t_chain(1'b1);
      t_stamp();
      results();
   end
endmodule : ptpev_tb_top
`default_nettype wire

// File: ptpev_top.sv
// PTP event trigger output units (four) and timestamp input units (two)
// with their indexed control registers, behind an Avalon-MM slave.
// Assumes system time arrives synchronous to clk; event pins likewise.
// Register map (byte offsets, bits 1:0 of the address ignored)
// 0x52c unit control and status:
//    bit 4 trigger unit active (read only), bit 3 trigger enable,
//    bit 2 trigger soft reset, bit 1 input enable, bit 0 input soft reset.
//    Trigger fields follow the trigger index; input fields the input index.
//    A write only acts when byte lane 0 is enabled.
// 0x530 target nanoseconds in bits 29:0 of the indexed trigger unit.
// 0x534 target seconds of the indexed trigger unit.
// 0x538 first trigger control word of the indexed trigger unit:
//    bit 31 chained, bit 30 final unit, bits 27:26 upstream unit,
//    bit 25 fire at once, bit 24 report done and error, bit 23 falling edge.
// 0x5f0 unit index: bits 1:0 trigger unit, bit 8 input unit.
// 0x5f4 interrupt status, cleared by reading it:
//    bits 3:0 done per trigger unit, bits 7:4 error per trigger unit,
//    bits 9:8 event seen per input unit.
// 0x5f8 interrupt mask, same layout as the status word.
// 0x5fc status of the indexed input unit:
//    bits 3:0 event count, bit 4 count overflow, bit 5 capture ready.
// Unmapped words read zero and ignore writes, yet are still answered.
//
// Bus timing
// A request is taken on the edge where it meets waitrequest high.
// Waitrequest then drops for exactly one cycle, with read data valid;
// the master releases at that edge and may ask again on the next one.
// A write is visible to a read that is taken one cycle later.
// Reset is synchronous and active low; every register clears to zero except
// the trigger unit states, which load TU_IDLE, and waitrequest, which rests high afterwards.
//
// Trigger unit timing
// Enabling a unit arms it; on the next edge it compares its target
// with system time. A target already reached fires at once; one still
// ahead is waited for; one gone by ends in an error unless fire-at-once
// is set. The output pulse lasts one clock, half a clock later when the
// falling edge is selected.
// Limitation: the falling-edge path is a second flip-flop selected per
// unit, so the output passes through one multiplexer after the flops.
// Limitation: the iteration count is not kept; a chain with a final
// unit runs through once, a chain without one loops until soft reset.
// Upstream select equal to the unit's own index never starts it.
//
// Input unit timing
// A rising edge on an enabled event pin counts once, sets ready and
// the event status bit, and is visible a cycle later. The count stops
// at its top value and then raises overflow instead of wrapping.
// Soft reset bits are stored and hold their unit at defaults while set.
`include "ptpev_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module ptpev_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [`PTPEV_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire ptpev_pkg::ptpev_time_t sys_time,
   input wire logic [1:0] stamp_event_in,
   output logic [3:0] trig_out,
   output logic irq
);
   import ptpev_pkg::*;

   ptpev_state_t s_q;
   ptpev_state_t s_d;
   logic [3:0] fall_q;

   // Byte-lane merge of write data over the current register value
   function automatic logic [31:0] be_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // System time at or past target, seconds compared first
   function automatic logic at_or_past(
      input ptpev_time_t t,
      input logic [31:0] sec,
      input logic [`PTPEV_NS_W-1:0] ns
   );
      return (t.sec > sec) || ((t.sec == sec) && (t.ns >= ns));
   endfunction : at_or_past

   // Next-state logic: bus slave, trigger engines, input units, interrupts
   always_comb begin
      logic acc;
      logic wr;
      logic [`PTPEV_AW-1:0] wa;
      logic [31:0] rw;
      logic [31:0] wd;
      logic [3:0] fire;
      logic [`PTPEV_IS_W-1:0] ev;
      logic [`PTPEV_IS_W-1:0] clr;
      logic [1:0] t;
      logic s;
      logic late;
      acc = 1'b0;
      wr = 1'b0;
      wa = '0;
      rw = `PTPEV_RST_WORD;
      wd = `PTPEV_RST_WORD;
      fire = '0;
      ev = '0;
      clr = '0;
      t = s_q.tidx;
      s = s_q.sidx;
      late = 1'b0;
      s_d = s_q;
      s_d.pulse = '0;

      // One access per request; waitrequest drops for exactly one cycle
      acc = (avs_read || avs_write) && s_q.waitreq;
      wr = acc && avs_write;
      wa = {avs_address[`PTPEV_AW-1:2], 2'b00};
      s_d.waitreq = !acc;

      // Read view of the addressed word; unmapped words read zero
      case (wa)
         `PTPEV_OFS_INDEX: begin
            rw[1:0] = s_q.tidx;
            rw[`PTPEV_IDX_TS_BIT] = s_q.sidx;
         end
         `PTPEV_OFS_TSCS: begin
            rw[`PTPEV_TSCS_ACT] = (s_q.tu[t].st != TU_IDLE);
            rw[`PTPEV_TSCS_TEN] = s_q.tu[t].en;
            rw[`PTPEV_TSCS_TSRST] = s_q.tu[t].output_unit_soft_reset;
            rw[`PTPEV_TSCS_SEN] = s_q.iu[s].stamp_unit_enable;
            rw[`PTPEV_TSCS_SSRST] = s_q.iu[s].input_unit_soft_reset;
         end
         `PTPEV_OFS_TNS: begin
            rw[`PTPEV_NS_W-1:0] = s_q.tu[t].target_nanoseconds;
         end
         `PTPEV_OFS_TSEC: begin
            rw = s_q.tu[t].target_seconds;
         end
         `PTPEV_OFS_CTL1: begin
            rw[`PTPEV_C1_CHAIN] = s_q.tu[t].chain_mode_enable;
            rw[`PTPEV_C1_TAIL] = s_q.tu[t].tail;
            rw[`PTPEV_C1_UPS_HI:`PTPEV_C1_UPS_LO] = s_q.tu[t].upsel;
            rw[`PTPEV_C1_NOW] = s_q.tu[t].now;
            rw[`PTPEV_C1_NOTIFY] = s_q.tu[t].notify;
            rw[`PTPEV_C1_EDGE] = s_q.tu[t].edge_neg;
         end
         `PTPEV_OFS_ISTAT: begin
            rw[`PTPEV_IS_W-1:0] = s_q.stat;
         end
         `PTPEV_OFS_IMASK: begin
            rw[`PTPEV_IS_W-1:0] = s_q.mask;
         end
         `PTPEV_OFS_TSSTAT: begin
            rw[`PTPEV_CNT_W-1:0] = s_q.iu[s].event_detect_count;
            rw[`PTPEV_TSS_OVF] = s_q.iu[s].detect_count_overflow;
            rw[`PTPEV_TSS_RDY] = s_q.iu[s].capture_ready_flag;
         end
         default: begin
            rw = `PTPEV_RST_WORD;
         end
      endcase
      if (acc && avs_read) begin
         s_d.rdata = rw;
      end

      // Trigger engines: arm checks for a past target, wait compares
      for (int i = 0; i < 4; i++) begin
         late = (sys_time.sec > s_q.tu[i].target_seconds) ||
                ((sys_time.sec == s_q.tu[i].target_seconds) &&
                 (sys_time.ns > s_q.tu[i].target_nanoseconds));
         case (s_q.tu[i].st)
            TU_IDLE: begin
               s_d.tu[i].st = TU_IDLE;
            end
            TU_ARM: begin
               if (late && !s_q.tu[i].now) begin
                  // Target already gone by: finish without output
                  s_d.tu[i].st = TU_IDLE;
                  s_d.tu[i].en = 1'b0;
                  ev[`PTPEV_IS_ERR + i] = s_q.tu[i].notify;
               end else if (late ||
                  at_or_past(sys_time, s_q.tu[i].target_seconds, s_q.tu[i].target_nanoseconds)) begin
                  fire[i] = 1'b1;
               end else begin
                  s_d.tu[i].st = TU_WAIT;
               end
            end
            TU_WAIT: begin
               if (at_or_past(sys_time, s_q.tu[i].target_seconds, s_q.tu[i].target_nanoseconds)) begin
                  fire[i] = 1'b1;
               end
            end
            default: begin
               s_d.tu[i].st = TU_IDLE;
            end
         endcase
         if (fire[i]) begin
            s_d.pulse[i] = 1'b1;
            s_d.tu[i].st = TU_IDLE;
            s_d.tu[i].en = 1'b0;
            ev[`PTPEV_IS_DONE + i] = s_q.tu[i].notify;
         end
      end

      // Chain hand-off: a non-final unit's done starts its downstream
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 4; j++) begin
            if (fire[j] && s_q.tu[j].chain_mode_enable && !s_q.tu[j].tail &&
                s_q.tu[k].chain_mode_enable && (j != k) &&
                (s_q.tu[k].upsel == 2'(j))) begin
               s_d.tu[k].st = TU_ARM;
            end
         end
      end

      // Input units count rising edges on their event pins
      for (int i = 0; i < 2; i++) begin
         s_d.iu[i].prev = stamp_event_in[i];
         if (s_q.iu[i].stamp_unit_enable && stamp_event_in[i] && !s_q.iu[i].prev) begin
            s_d.iu[i].capture_ready_flag = 1'b1;
            ev[`PTPEV_IS_RDY + i] = 1'b1;
            if (&s_q.iu[i].event_detect_count) begin
               // Count saturates rather than wrap, so software sees the loss
               s_d.iu[i].detect_count_overflow = 1'b1;
            end else begin
               s_d.iu[i].event_detect_count = s_q.iu[i].event_detect_count + 1'b1;
            end
         end
      end

      // Register writes, after the engines so software wins a tie, except the input flags on a disable
      wd = be_merge(rw, avs_writedata, avs_byteenable);
      if (wr) begin
         case (wa)
            `PTPEV_OFS_INDEX: begin
               s_d.tidx = wd[1:0];
               s_d.sidx = wd[`PTPEV_IDX_TS_BIT];
            end
            `PTPEV_OFS_TSCS: begin
               if (avs_byteenable[0]) begin
                  s_d.tu[t].output_unit_soft_reset = wd[`PTPEV_TSCS_TSRST];
                  if (!wd[`PTPEV_TSCS_TEN]) begin
                     s_d.tu[t].en = 1'b0;
                     s_d.tu[t].st = TU_IDLE;
                  end else if (!s_q.tu[t].en) begin
                     s_d.tu[t].en = 1'b1;
                     s_d.tu[t].st = TU_ARM;
                  end
                  s_d.iu[s].input_unit_soft_reset = wd[`PTPEV_TSCS_SSRST];
                  s_d.iu[s].stamp_unit_enable = wd[`PTPEV_TSCS_SEN];
                  if (wd[`PTPEV_TSCS_SEN]) begin
                     s_d.iu[s].event_detect_count = '0;
                  end else begin
                     // Flags that a same-cycle event raises survive the clear
                     s_d.iu[s].capture_ready_flag = ev[`PTPEV_IS_RDY + s];
                     s_d.iu[s].detect_count_overflow = ev[`PTPEV_IS_RDY + s] &&
                        (&s_q.iu[s].event_detect_count);
                  end
               end
            end
            `PTPEV_OFS_TNS: begin
               s_d.tu[t].target_nanoseconds = wd[`PTPEV_NS_W-1:0];
            end
            `PTPEV_OFS_TSEC: begin
               s_d.tu[t].target_seconds = wd;
            end
            `PTPEV_OFS_CTL1: begin
               s_d.tu[t].chain_mode_enable = wd[`PTPEV_C1_CHAIN];
               s_d.tu[t].tail = wd[`PTPEV_C1_TAIL];
               s_d.tu[t].upsel = wd[`PTPEV_C1_UPS_HI:`PTPEV_C1_UPS_LO];
               s_d.tu[t].now = wd[`PTPEV_C1_NOW];
               s_d.tu[t].notify = wd[`PTPEV_C1_NOTIFY];
               s_d.tu[t].edge_neg = wd[`PTPEV_C1_EDGE];
            end
            `PTPEV_OFS_IMASK: begin
               s_d.mask = wd[`PTPEV_IS_W-1:0];
            end
            default: begin
               s_d.mask = s_d.mask;
            end
         endcase
      end

      // Soft resets hold their unit at defaults while set
      for (int i = 0; i < 4; i++) begin
         if (s_d.tu[i].output_unit_soft_reset) begin
            s_d.tu[i] = '0;
            s_d.tu[i].output_unit_soft_reset = 1'b1;
            s_d.tu[i].st = TU_IDLE;
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (s_d.iu[i].input_unit_soft_reset) begin
            s_d.iu[i].stamp_unit_enable = 1'b0;
            s_d.iu[i].capture_ready_flag = 1'b0;
            s_d.iu[i].detect_count_overflow = 1'b0;
            s_d.iu[i].event_detect_count = '0;
         end
      end

      // Sticky status: read clears, a same-cycle event still sets
      if (acc && avs_read && (wa == `PTPEV_OFS_ISTAT)) begin
         clr = s_q.stat;
      end
      s_d.stat = (s_q.stat & ~clr) | ev;
      s_d.irq = |(s_d.stat & s_d.mask);
   end

   // State register; waitrequest rests high so a request waits one cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.waitreq <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            s_q.tu[i].st <= TU_IDLE;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // Half-cycle delayed copy of the fire pulses for falling-edge timing
   always_ff @(negedge clk) begin
      if (!resetn) begin
         fall_q <= '0;
      end else begin
         fall_q <= s_q.pulse;
      end
   end

   // Output selection per unit; both sources are flip-flops
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         trig_out[i] = s_q.tu[i].edge_neg ? fall_q[i] : s_q.pulse[i];
      end
   end

   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.waitreq;
   assign irq = s_q.irq;

endmodule : ptpev_top

`default_nettype wire
